// ### verilog/drsg_regs.svh
/*
 * Timing counts and widths for the data-ready sync gate.
 * Assumes a single 40 MHz output-domain clock.
 */
`ifndef DRSG_REGS_SVH
`define DRSG_REGS_SVH

`define DRSG_SAMPLE_W        12
`define DRSG_FIFO_DEPTH      16
`define DRSG_CLK_PERIOD_PS   25000
`define DRSG_HOLD_MIN_PS     5000
`define DRSG_SYNC_STAGES     2

`endif

// ### verilog/drsg_pkg.sv
/*
 * Types for the data-ready sync gate.
 * Assumes drsg_regs.svh is on the include path.
 */
`default_nettype none
package drsg_pkg;
	typedef enum logic [1:0] {
		DRSG_RUN  = 2'b00,
		DRSG_HOLD = 2'b01,
		DRSG_WAIT = 2'b11
	} drsg_state_t;
endpackage : drsg_pkg
`default_nettype wire

// ### verilog/drsg_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`default_nettype none
module drsg_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	wire              push;
	wire              pop;

	assign in_ready_out  = (count_r != (AW+1)'(DEPTH));
	assign out_valid_out = (count_r != '0);
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;
	assign out_data_out  = mem[rd_ptr_r];

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
			end
			if (pop) begin
				rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : drsg_fifo
`default_nettype wire

// ### verilog/drsg_gate.sv
/*
 * Output-side control of an interleaved converter: pairs of A/B samples
 * pass through a FIFO to two half-rate buses with data-ready strobes that
 * a capture-alignment hold pin can suppress; a jumper picks corrected or
 * raw samples.
 * Assumes pair inputs and corrected inputs are on clk_in; the hold pin and
 * the jumper are asynchronous pins.
 */
`include "drsg_regs.svh"
`default_nettype none
module drsg_gate #(
	parameter int W     = `DRSG_SAMPLE_W,
	parameter int DEPTH = `DRSG_FIFO_DEPTH
) (
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	input  wire logic         capture_hold_in,
	input  wire logic         correction_enable_jumper_in,
	input  wire logic         pair_valid_in,
	output logic              pair_ready_out,
	input  wire logic [W-1:0] raw_a_in,
	input  wire logic [W-1:0] raw_b_in,
	input  wire logic [W-1:0] corr_a_in,
	input  wire logic [W-1:0] corr_b_in,
	output logic      [W-1:0] bus_a_out,
	output logic      [W-1:0] bus_b_out,
	output logic              data_ready_bus_a_out,
	output logic              data_ready_bus_b_out,
	output logic              holding_out
);
	// Never fewer than two synchroniser stages
	localparam int NS = (`DRSG_SYNC_STAGES < 2) ? 2 : `DRSG_SYNC_STAGES;

	logic [NS-1:0]         hold_sync_r;
	logic [1:0]            jmp_sync_r;
	drsg_pkg::drsg_state_t state_r;
	drsg_pkg::drsg_state_t state_nxt;
	logic [W-1:0]          bus_a_r;
	logic [W-1:0]          bus_b_r;
	logic                  dra_r;
	logic                  drb_r;
	logic                  hold_latch_r;

	wire                   hold_s;
	wire                   corr_on;
	wire [2*W-1:0]         fifo_in;
	wire [2*W-1:0]         fifo_out;
	wire                   fifo_valid;
	wire                   fifo_pop;
	wire                   running;

	// Pins are read only after their last synchroniser stage
	assign hold_s  = hold_sync_r[NS-1];
	assign corr_on = jmp_sync_r[1];
	assign fifo_in = corr_on ? {corr_a_in, corr_b_in} : {raw_a_in, raw_b_in};
	assign running = (state_r == drsg_pkg::DRSG_RUN) && !hold_s;
	// Data drains only while strobing; held pairs back up into the FIFO
	assign fifo_pop = running && fifo_valid;

	drsg_fifo #(.WIDTH(2*W), .DEPTH(DEPTH)) u_fifo (
		.clk_in        (clk_in),
		.rst_n_in      (rst_n_in),
		.in_valid_in   (pair_valid_in),
		.in_ready_out  (pair_ready_out),
		.in_data_in    (fifo_in),
		.out_valid_out (fifo_valid),
		.out_ready_in  (running),
		.out_data_out  (fifo_out)
	);

	// Pin synchronisers; a hold level must span a clock edge to be seen
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			hold_sync_r  <= '0;
			jmp_sync_r   <= '0;
			hold_latch_r <= 1'b0;
		end else begin
			hold_sync_r  <= {hold_sync_r[NS-2:0], capture_hold_in};
			jmp_sync_r   <= {jmp_sync_r[0], correction_enable_jumper_in};
			hold_latch_r <= hold_s;
		end
	end

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			drsg_pkg::DRSG_RUN: begin
				if (hold_s) begin
					state_nxt = drsg_pkg::DRSG_HOLD;
				end
			end
			drsg_pkg::DRSG_HOLD: begin
				if (!hold_s) begin
					state_nxt = drsg_pkg::DRSG_WAIT;
				end
			end
			drsg_pkg::DRSG_WAIT: begin
				if (hold_s) begin
					state_nxt = drsg_pkg::DRSG_HOLD;
				end else begin
					state_nxt = drsg_pkg::DRSG_RUN;
				end
			end
			default: begin
				state_nxt = drsg_pkg::DRSG_HOLD;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_r <= drsg_pkg::DRSG_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// A and B strobe together per pair, so restart is always on an A event
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			bus_a_r <= '0;
			bus_b_r <= '0;
			dra_r   <= 1'b0;
			drb_r   <= 1'b0;
		end else begin
			dra_r <= fifo_pop;
			drb_r <= fifo_pop;
			if (fifo_pop) begin
				bus_a_r <= fifo_out[2*W-1:W];
				bus_b_r <= fifo_out[W-1:0];
			end
		end
	end

	assign bus_a_out            = bus_a_r;
	assign bus_b_out            = bus_b_r;
	assign data_ready_bus_a_out = dra_r;
	assign data_ready_bus_b_out = drb_r;
	assign holding_out          = hold_latch_r || (state_r != drsg_pkg::DRSG_RUN);
endmodule : drsg_gate
`default_nettype wire

// ### verif/drsg_gate_asserts.sv
/* Port assertions for drsg_gate.
   Assumes one clock and the bind at the foot of this file. */
`default_nettype none
module drsg_gate_chk #(parameter int W = 12) (
	input wire logic         clk_in,
	input wire logic         rst_n_in,
	input wire logic         capture_hold_in,
	input wire logic         pair_valid_in,
	input wire logic         pair_ready_out,
	input wire logic [W-1:0] bus_a_out,
	input wire logic [W-1:0] bus_b_out,
	input wire logic         data_ready_bus_a_out,
	input wire logic         data_ready_bus_b_out,
	input wire logic         holding_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_calm; (!capture_hold_in)[*8]; endsequence
	sequence s_take; pair_valid_in && pair_ready_out; endsequence
	a_strobes_paired: assert property (data_ready_bus_a_out == data_ready_bus_b_out)
		else $error("strobes apart");
	a_hold_blocks: assert property (capture_hold_in[*3] |=> !data_ready_bus_a_out)
		else $error("strobe in hold");
	a_hold_synced: assert property (!holding_out && $rose(capture_hold_in) |=> !holding_out)
		else $error("hold unsynced");
	a_hold_seen: assert property (capture_hold_in[*4] |=> holding_out)
		else $error("hold missed");
	a_held_quiet: assert property (holding_out |=> !data_ready_bus_b_out)
		else $error("strobe while holding");
	a_bus_kept: assert property (!data_ready_bus_a_out |-> $stable(bus_a_out) && $stable(bus_b_out))
		else $error("bus moved");
	a_flow_resumes: assert property (s_calm ##0 s_take |-> ##[1:3] data_ready_bus_a_out)
		else $error("no strobe");
endmodule : drsg_gate_chk
bind drsg_gate drsg_gate_chk #(.W(W)) drsg_gate_chk_inst (.clk_in, .rst_n_in, .capture_hold_in,
	.pair_valid_in, .pair_ready_out, .bus_a_out, .bus_b_out, .data_ready_bus_a_out,
	.data_ready_bus_b_out, .holding_out);
`default_nettype wire

// ### verif/drsg_capture_model.sv
/* Capture board model: drives the hold pin off-clock, or on the edge when sync_in is high, and counts pairs.
   Assumes the gate's clock and strobe. */
`default_nettype none
module drsg_capture_model (
	input wire logic clk_in,
	input wire logic sync_in,
	input wire logic hold_req_in,
	input wire logic strobe_in,
	output var logic hold_out,
	output var int   pairs_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial hold_out = 1'b0;
	initial pairs_out = 0;
	// Level lasts whole periods; off the clock edge, or on it when sync_in is high
	always @(negedge clk_in) if (!sync_in) hold_out <= #7 hold_req_in;
	always @(posedge clk_in) if (sync_in) hold_out <= hold_req_in;
	always @(posedge clk_in) if (strobe_in) pairs_out <= pairs_out + 1;
endmodule : drsg_capture_model
`default_nettype wire

// ### verif/testbench.sv
/* Self-checking bench for drsg_gate.
   Assumes the capture model and the checker are compiled alongside. */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in = 0, rst_n_in = 0, jmp = 1, valid = 0, hold_req = 0, hsync = 0, hold, rdy, data_ready_bus_a, data_ready_bus_b, held;
	logic [11:0] ra = 0, rb = 0, ca = 0, cb = 0, ba, bb;
	int          fail_count = 0, tests_run = 0, seed = 32'h130eeaeb, sent = 0, got, snap;
	logic [23:0] q[$];
	always #12.5 clk_in = ~clk_in;
	drsg_gate drsg_gate_inst (.clk_in, .rst_n_in, .capture_hold_in(hold), .correction_enable_jumper_in(jmp),
		.pair_valid_in(valid), .pair_ready_out(rdy), .raw_a_in(ra), .raw_b_in(rb), .corr_a_in(ca),
		.corr_b_in(cb), .bus_a_out(ba), .bus_b_out(bb), .data_ready_bus_a_out(data_ready_bus_a),
		.data_ready_bus_b_out(data_ready_bus_b), .holding_out(held));
	drsg_capture_model drsg_capture_model_inst (.clk_in, .sync_in(hsync), .hold_req_in(hold_req), .strobe_in(data_ready_bus_a),
		.hold_out(hold), .pairs_out(got));
	function automatic logic [23:0] pick(input logic j, input logic [11:0] a, b, c, d);
		return j ? {c, d} : {a, b};
	endfunction : pick
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] seen);
		tests_run++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, seen);
			fail_count++;
		end
	endtask : check
	always @(posedge clk_in) if (rst_n_in) begin
		if (valid && rdy) begin
			q.push_back(pick(jmp, ra, rb, ca, cb));
			sent++;
		end
		if (data_ready_bus_a) check("pair", q.size() ? q.pop_front() : 24'hx, {ba, bb});
	end
	task automatic traffic(input int n);
		repeat (n) begin
			@(negedge clk_in);
			valid = 1'($random(seed));
			{ra, rb, ca, cb} = 48'({$random(seed), $random(seed)});
		end
		@(negedge clk_in) valid = 0;
		repeat (8) @(negedge clk_in);
	endtask : traffic
	task automatic hold_round(input logic on_edge);
		hsync = on_edge;
		hold_req = 1;
		repeat (4) @(negedge clk_in);
		snap = got;
		{valid, ra, rb, ca, cb} = {1'b1, 12'h7ff, 12'h800, 12'h000, 12'hfff};
		repeat (24) @(negedge clk_in);
		check("ready when full", 24'h0, {23'h0, rdy});
		check("holding", 24'h1, {23'h0, held});
		check("pairs during hold", 24'(snap), 24'(got));
		valid = 0;
		hold_req = 0;
		for (int i = 0; i < 100 && q.size() > 0; i++) @(negedge clk_in);
		check("queue left", 24'h0, 24'(q.size()));
		$display("hold and release done");
	endtask : hold_round
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (5) @(negedge clk_in);
		rst_n_in = 1;
		// Let the jumper synchroniser settle before pairs are offered
		repeat (3) @(negedge clk_in);
		traffic(40);
		$display("corrected stream done");
		jmp = 0;
		repeat (3) @(negedge clk_in);
		traffic(40);
		$display("raw stream done");
		hold_round(1'b0);
		hold_round(1'b1);
		check("pairs captured", 24'(sent), 24'(got));
		@(negedge clk_in) rst_n_in = 0;
		repeat (3) @(negedge clk_in);
		check("reset state", 24'h1, {20'h0, held, data_ready_bus_a, data_ready_bus_b, rdy});
		check("reset bus", 24'h0, {ba, bb});
		rst_n_in = 1;
		traffic(20);
		check("pairs after reset", 24'(sent), 24'(got));
		$display("reset and resume done");
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
